// ===== logic/utg_pkg.sv
// Shared constants and types for the gated UART transmit and half-duplex block
package utg_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned BAUD_DEFAULT = 115_200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
	localparam int CNT_W = 16;
	localparam int DATA_BITS = 8;
	// Register byte addresses
	localparam logic [31:0] ADDR_DATA = 32'h4000_8000;
	localparam logic [31:0] ADDR_STATUS = 32'h4000_8014;
	localparam logic [31:0] ADDR_GATE = 32'h4000_8030;
	localparam logic [31:0] ADDR_HD = 32'h4000_8040;
	// Field positions
	localparam int PERMIT_BIT = 7;
	localparam int HD_BIT = 0;
	localparam int ST_HOLD_FULL = 0;
	localparam int ST_TX_BUSY = 1;
	localparam int ST_RX_VALID = 2;
	localparam int ST_RX_BUSY = 3;
	localparam int ST_RX_LOCKED = 4;
	localparam int ST_FRAME_ERR = 5;
	// Values after reset
	localparam logic RST_PERMIT = 1'b1;
	localparam logic RST_HD = 1'b0;
	localparam logic RST_LINE = 1'b1;
	// Serial frame states
	typedef enum logic [1:0] {
		UTG_IDLE = 2'b00,
		UTG_START = 2'b01,
		UTG_DATA = 2'b10,
		UTG_STOP = 2'b11
	} utg_state_t;
endpackage

// ===== logic/utg_tx_shift.sv
// Transmit shift register: one 8N1 frame per start pulse
`timescale 1ns/100ps
module utg_tx_shift
	import utg_pkg::*;
#(
	parameter int BIT_CYCLES_P = BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] data,
	output logic txd,
	output logic busy,
	output logic done
);
	utg_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic txd_reg, txd_next;
	logic done_reg, done_next;
	logic tick;

	// Bit timing and frame sequencing
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		txd_next = txd_reg;
		done_next = 1'b0;
		tick = (cnt_reg == CNT_W'(BIT_CYCLES_P - 1));
		cnt_next = (state_reg == UTG_IDLE || tick) ? '0 : cnt_reg + 1'b1;
		case (state_reg)
			UTG_IDLE: begin
				txd_next = 1'b1;
				if (start) begin
					shift_next = data;
					txd_next = 1'b0;
					state_next = UTG_START;
				end
			end
			UTG_START: begin
				if (tick) begin
					txd_next = shift_reg[0];
					bit_next = '0;
					state_next = UTG_DATA;
				end
			end
			UTG_DATA: begin
				if (tick) begin
					if (bit_reg == 3'h7) begin
						txd_next = 1'b1;
						state_next = UTG_STOP;
					end else begin
						shift_next = shift_reg >> 1;
						txd_next = shift_reg[1];
						bit_next = bit_reg + 1'b1;
					end
				end
			end
			UTG_STOP: begin
				if (tick) begin
					done_next = 1'b1; // Frame fully sent
					state_next = UTG_IDLE;
				end
			end
			default: state_next = UTG_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= UTG_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			txd_reg <= RST_LINE;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			txd_reg <= txd_next;
			done_reg <= done_next;
		end
	end

	assign txd = txd_reg;
	assign busy = (state_reg != UTG_IDLE);
	assign done = done_reg;
endmodule

// ===== logic/utg_rx_shift.sv
// Receive shift register: samples an 8N1 frame from the filtered line level
`timescale 1ns/100ps
module utg_rx_shift
	import utg_pkg::*;
#(
	parameter int BIT_CYCLES_P = BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_level,
	input wire logic enable,
	output logic [7:0] data,
	output logic valid,
	output logic frame_err,
	output logic busy
);
	utg_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] data_reg, data_next;
	logic valid_reg, valid_next;
	logic err_reg, err_next;
	logic tick;
	logic half;

	// Start detection, mid-bit sampling and stop check
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		data_next = data_reg;
		valid_next = 1'b0;
		err_next = 1'b0;
		tick = (cnt_reg == CNT_W'(BIT_CYCLES_P - 1));
		half = (cnt_reg == CNT_W'(BIT_CYCLES_P / 2 - 1));
		cnt_next = cnt_reg + 1'b1;
		case (state_reg)
			UTG_IDLE: begin
				cnt_next = '0;
				if (enable && !rx_level) begin
					state_next = UTG_START; // New frames only start while unlocked
				end
			end
			UTG_START: begin
				if (half) begin
					cnt_next = '0;
					bit_next = '0;
					state_next = rx_level ? UTG_IDLE : UTG_DATA; // Glitch rejection
				end
			end
			UTG_DATA: begin
				if (tick) begin
					cnt_next = '0;
					shift_next = {rx_level, shift_reg[7:1]};
					bit_next = bit_reg + 1'b1;
					if (bit_reg == 3'h7) begin
						state_next = UTG_STOP;
					end
				end
			end
			UTG_STOP: begin
				if (tick) begin
					data_next = shift_reg;
					valid_next = 1'b1;
					err_next = !rx_level;
					state_next = UTG_IDLE;
				end
			end
			default: state_next = UTG_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= UTG_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			data_reg <= '0;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			data_reg <= data_next;
			valid_reg <= valid_next;
			err_reg <= err_next;
		end
	end

	assign data = data_reg;
	assign valid = valid_reg;
	assign frame_err = err_reg;
	assign busy = (state_reg != UTG_IDLE);
endmodule

// ===== logic/utg_top.sv
// Serial port with transmit permit gate and half-duplex receiver lock
// Functional notes
// - Permit set: send held character when transmitter free
// - Permit cleared mid-character: finish it, then stop
// - Permit zero blocks holding-to-shift register transfer
// - Permit reads one after reset
// - Full duplex after reset
// - Half-duplex select bit enters or leaves half duplex
// - Half duplex: lock receiver idle while a character is held or being sent, after ongoing character
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
module utg_top
	import utg_pkg::*;
#(
	parameter int BIT_CYCLES_P = BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxd,
	output logic txd
);
	// Bus slave state
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic accept;
	logic wr_data, wr_gate, wr_hd, rd_data, rd_status;

	// Control and data state
	logic permit_reg, permit_next;
	logic hd_reg, hd_next;
	logic hold_full_reg, hold_full_next;
	logic [7:0] hold_data_reg, hold_data_next;
	logic tx_start_reg, tx_start_next;
	logic load;
	logic rx_locked_reg, rx_locked_next;
	logic lock_req;
	logic rx_valid_reg, rx_valid_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic frame_err_reg, frame_err_next;

	// Line input synchroniser and filter
	logic sync1_reg, sync2_reg, sync3_reg;
	logic rx_level_reg, rx_level_next;

	// Sub-block outputs
	logic tx_txd, tx_busy, tx_done;
	logic [7:0] rx_byte;
	logic rx_pulse, rx_err, rx_busy;

	// Access decode: one accepted cycle per request
	always_comb begin
		accept = (avs_read || avs_write) && wait_reg;
		wr_data = accept && avs_write && (avs_address == ADDR_DATA);
		wr_gate = accept && avs_write && (avs_address == ADDR_GATE);
		wr_hd = accept && avs_write && (avs_address == ADDR_HD);
		rd_data = accept && avs_read && (avs_address == ADDR_DATA);
		rd_status = accept && avs_read && (avs_address == ADDR_STATUS);
	end

	// Wait state and read data; unmapped reads return zero
	always_comb begin
		wait_next = !accept;
		rdata_next = rdata_reg;
		if (accept && avs_read) begin
			case (avs_address)
				ADDR_DATA: rdata_next = {24'h0, rx_data_reg};
				ADDR_STATUS: begin
					rdata_next = 32'h0;
					rdata_next[ST_HOLD_FULL] = hold_full_reg;
					rdata_next[ST_TX_BUSY] = tx_busy;
					rdata_next[ST_RX_VALID] = rx_valid_reg;
					rdata_next[ST_RX_BUSY] = rx_busy;
					rdata_next[ST_RX_LOCKED] = rx_locked_reg;
					rdata_next[ST_FRAME_ERR] = frame_err_reg;
				end
				ADDR_GATE: begin
					rdata_next = 32'h0;
					rdata_next[PERMIT_BIT] = permit_reg;
				end
				ADDR_HD: begin
					rdata_next = 32'h0;
					rdata_next[HD_BIT] = hd_reg;
				end
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Transmit path: holding register gated into the shifter by the permit
	always_comb begin
		permit_next = permit_reg;
		hold_full_next = hold_full_reg;
		hold_data_next = hold_data_reg;
		if (wr_gate) begin
			permit_next = avs_writedata[PERMIT_BIT]; // Reserved bits ignored
		end
		// Transfer only with permit set and shifter free
		// The shifter never sees the permit, so a frame in flight ends whole
		load = hold_full_reg && permit_reg && !tx_busy && !tx_start_reg;
		tx_start_next = load;
		if (load) begin
			hold_full_next = 1'b0;
		end else if (wr_data && !hold_full_reg) begin
			hold_full_next = 1'b1; // A write while full is dropped
			hold_data_next = avs_writedata[7:0];
		end
		// Without permit the held character simply stays
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			permit_reg <= RST_PERMIT; // Transmission allowed by default
			hold_full_reg <= 1'b0;
			hold_data_reg <= 8'h00;
			tx_start_reg <= 1'b0;
		end else begin
			permit_reg <= permit_next;
			hold_full_reg <= hold_full_next;
			hold_data_reg <= hold_data_next;
			tx_start_reg <= tx_start_next;
		end
	end

	// Half-duplex select and receiver lock
	always_comb begin
		hd_next = wr_hd ? avs_writedata[HD_BIT] : hd_reg;
		lock_req = hd_reg && (tx_busy || hold_full_reg || tx_start_reg);
		if (!hd_reg) begin
			rx_locked_next = 1'b0; // Full duplex: receiver independent
		end else if (rx_busy) begin
			rx_locked_next = rx_locked_reg; // Ongoing character completes
		end else begin
			rx_locked_next = lock_req; // Idle receiver locks at once
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hd_reg <= RST_HD;
			rx_locked_reg <= 1'b0;
		end else begin
			hd_reg <= hd_next;
			rx_locked_reg <= rx_locked_next;
		end
	end

	// Receive data and sticky flags; a new event wins over the read clear
	always_comb begin
		rx_data_next = rx_pulse ? rx_byte : rx_data_reg;
		rx_valid_next = rx_pulse ? 1'b1 : (rd_data ? 1'b0 : rx_valid_reg);
		frame_err_next = (rx_pulse && rx_err) ? 1'b1 : (rd_status ? 1'b0 : frame_err_reg);
		rx_level_next = (sync2_reg == sync3_reg) ? sync3_reg : rx_level_reg;
	end

	// Three-stage line synchroniser; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= RST_LINE;
			sync2_reg <= RST_LINE;
			sync3_reg <= RST_LINE;
			rx_level_reg <= RST_LINE;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			frame_err_reg <= 1'b0;
		end else begin
			sync1_reg <= rxd;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			rx_level_reg <= rx_level_next;
			rx_data_reg <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			frame_err_reg <= frame_err_next;
		end
	end

	// Serial shifters
	utg_tx_shift #(
		.BIT_CYCLES_P(BIT_CYCLES_P)
	) u_tx (
		.clk(clk),
		.rst(rst),
		.start(tx_start_reg),
		.data(hold_data_reg),
		.txd(tx_txd),
		.busy(tx_busy),
		.done(tx_done)
	);

	utg_rx_shift #(
		.BIT_CYCLES_P(BIT_CYCLES_P)
	) u_rx (
		.clk(clk),
		.rst(rst),
		.rx_level(rx_level_reg),
		.enable(!rx_locked_reg),
		.data(rx_byte),
		.valid(rx_pulse),
		.frame_err(rx_err),
		.busy(rx_busy)
	);

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign txd = tx_txd;

	// Checks on the gate, the lock and the reset state
	sequence seq_ready_to_load;
		hold_full_reg && permit_reg && !tx_busy && !tx_start_reg;
	endsequence

	sequence seq_gated_queue;
		hold_full_reg && !permit_reg;
	endsequence

	property p_load;
		@(posedge clk) disable iff (rst)
		seq_ready_to_load |=> (tx_start_reg && !hold_full_reg) ##1 tx_busy;
	endproperty

	property p_keep_queue;
		@(posedge clk) disable iff (rst)
		seq_gated_queue |=> hold_full_reg && $stable(hold_data_reg);
	endproperty

	AST_LOAD_WITH_PERMIT: assert property (p_load)
		else $error("held character not passed to shifter");
	AST_FINISH_CHAR: assert property (@(posedge clk) disable iff (rst)
		(tx_busy && !permit_reg) |=> (tx_busy || tx_done))
		else $error("character cut short after permit cleared");
	AST_BLOCK_NO_PERMIT: assert property (@(posedge clk) disable iff (rst)
		!permit_reg |=> !tx_start_reg)
		else $error("transfer started without permit");
	AST_RESET_PERMIT: assert property (@(posedge clk)
		$past(rst) |-> (permit_reg && !hold_full_reg))
		else $error("permit not set after reset");
	AST_RESET_FULL_DUPLEX: assert property (@(posedge clk)
		$past(rst) |-> (!hd_reg && !rx_locked_reg))
		else $error("not full duplex after reset");
	AST_HD_WRITE: assert property (@(posedge clk) disable iff (rst)
		wr_hd |=> (hd_reg == $past(avs_writedata[HD_BIT])))
		else $error("half-duplex select not updated");
	AST_LOCK_HOLD_BUSY: assert property (@(posedge clk) disable iff (rst)
		(hd_reg && rx_busy && !wr_hd) |=> $stable(rx_locked_reg))
		else $error("lock changed during reception");
	AST_LOCK_IDLE: assert property (@(posedge clk) disable iff (rst)
		(hd_reg && !rx_busy && lock_req && !wr_hd) |=> rx_locked_reg)
		else $error("idle receiver not locked");
	AST_KEEP_QUEUED: assert property (p_keep_queue)
		else $error("queued character lost while gated");

	// Check helper: counts the cycles of each busy span of the transmitter
	logic [CNT_W-1:0] busy_len_reg, busy_len_next;

	always_comb begin
		busy_len_next = tx_busy ? busy_len_reg + 1'b1 : '0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_len_reg <= '0;
		end else begin
			busy_len_reg <= busy_len_next;
		end
	end

	AST_FRAME_LENGTH: assert property (@(posedge clk) disable iff (rst)
		$fell(tx_busy) |-> (busy_len_reg == CNT_W'((DATA_BITS + 2) * BIT_CYCLES_P)))
		else $error("frame length differs from ten bit times");
	AST_NEXT_CHAR_AT_ONCE: assert property (@(posedge clk) disable iff (rst)
		(tx_done && hold_full_reg && permit_reg) |=> tx_start_reg)
		else $error("held character not started after previous frame");
	AST_START_IDLE_ONLY: assert property (@(posedge clk) disable iff (rst)
		tx_start_reg |-> !tx_busy)
		else $error("transfer started while shifter busy");
	AST_PERMIT_WRITE: assert property (@(posedge clk) disable iff (rst)
		wr_gate |=> (permit_reg == $past(avs_writedata[PERMIT_BIT])))
		else $error("transmit permit not updated");
	AST_UNLOCK_FULL_DUPLEX: assert property (@(posedge clk) disable iff (rst)
		!hd_reg |=> !rx_locked_reg)
		else $error("receiver locked in full duplex");
	AST_NO_LOCK_WITHOUT_WORK: assert property (@(posedge clk) disable iff (rst)
		(hd_reg && !rx_busy && !lock_req) |=> !rx_locked_reg)
		else $error("receiver locked with no transmit work");
endmodule

// ===== bench/utg_peer.sv
// Remote serial peer: decodes frames seen on txd and sends frames on rxd
`timescale 1ns/100ps
module utg_peer #(
	parameter int BC = 8
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// Line rests high, as a pulled-up idle line
	initial begin
		rxd = 1'b1;
	end
	// Decode 8N1 LSB first at mid-bit; a low stop bit is stored as unknown
	always begin
		@(negedge txd);
		repeat (BC / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(negedge clk);
			sh[i] = txd;
		end
		repeat (BC) @(negedge clk);
		got.push_back((txd === 1'b1) ? sh : 8'hXX);
	end
	// Send one frame only when the bench asks, never on its own
	task automatic send(input logic [7:0] b);
		send_raw({1'b1, b, 1'b0});
	endtask
	// Send ten line bits as given, then rest the line high
	task automatic send_raw(input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BC - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule

// ===== bench/tb_uart_tx_gate_half_duplex.sv
// Self-checking bench for the gated transmit and half-duplex serial port
`timescale 1ns/100ps
module tb_uart_tx_gate_half_duplex;
	import utg_pkg::*;
	localparam int BC = 8;
	typedef struct {logic wr; logic [31:0] addr; logic [31:0] data; logic [31:0] exp;} utg_row_t;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, rxd, txd;
	logic [31:0] avs_address, avs_writedata, avs_readdata, rd;
	logic [7:0] exp_q[$];
	int error_cnt, checks;
	// Register rows: optional write, then a read that must give exp
	utg_row_t rows[9] = '{
		'{1'b0, ADDR_GATE, 32'h0, 32'h0000_0080},
		'{1'b0, ADDR_HD, 32'h0, 32'h0},
		'{1'b0, ADDR_STATUS, 32'h0, 32'h0},
		'{1'b0, 32'h4000_8044, 32'h0, 32'h0},
		'{1'b1, ADDR_GATE, 32'h0, 32'h0},
		'{1'b1, ADDR_GATE, 32'h0000_0080, 32'h0000_0080},
		'{1'b1, ADDR_HD, 32'h1, 32'h1},
		'{1'b1, ADDR_HD, 32'h0, 32'h0},
		'{1'b1, 32'h4000_8044, 32'hFF, 32'h0}
	};

	utg_top #(.BIT_CYCLES_P(BC)) utg_top_i (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
	utg_peer #(.BC(BC)) utg_peer_i (.clk(clk), .txd(txd), .rxd(rxd));

	// Clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// One bus cycle; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Queue a character and remember it as expected on the line
	task automatic put(input logic [7:0] b);
		exp_q.push_back(b);
		bus(1'b1, ADDR_DATA, {24'h0, b});
	endtask

	task automatic stat(input int b, input logic v);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, rd[b]}, {31'h0, v});
	endtask

	task automatic wait_peer(input int n);
		while (utg_peer_i.got.size() < n) @(posedge clk);
	endtask

	task automatic test_done;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("[ERR] %0t timeout", $time);
		test_done();
	end

	// Main sequence
	initial begin
		rst <= 1'b1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= 32'h0;
		avs_writedata <= 32'h0;
		error_cnt = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) bus(1'b1, rows[i].addr, rows[i].data);
			bus(1'b0, rows[i].addr, 32'h0);
			chk(rd, rows[i].exp);
		end
		// Back-to-back characters with permit set
		put(8'hA5);
		stat(ST_HOLD_FULL, 1'b0);
		put(8'h3C);
		wait_peer(2);
		// Permit cleared mid-character, as software does on an XOFF
		put(8'h55);
		while (txd !== 1'b0) @(posedge clk);
		bus(1'b1, ADDR_GATE, 32'h0);
		stat(ST_TX_BUSY, 1'b1);
		put(8'h66);
		repeat (30 * BC) @(posedge clk);
		chk(32'(utg_peer_i.got.size()), 32'd3);
		stat(ST_HOLD_FULL, 1'b1);
		bus(1'b1, ADDR_GATE, 32'h0000_0080);
		wait_peer(4);
		// Half duplex with transmitter holding work: receiver locked
		bus(1'b1, ADDR_GATE, 32'h0);
		bus(1'b1, ADDR_HD, 32'h1);
		put(8'h77);
		stat(ST_RX_LOCKED, 1'b1);
		utg_peer_i.send(8'h99);
		repeat (2 * BC) @(posedge clk);
		stat(ST_RX_VALID, 1'b0);
		// Back to full duplex: receive while transmitting
		bus(1'b1, ADDR_HD, 32'h0);
		stat(ST_RX_LOCKED, 1'b0);
		fork
			utg_peer_i.send(8'h5A);
			bus(1'b1, ADDR_GATE, 32'h0000_0080);
		join
		repeat (2 * BC) @(posedge clk);
		bus(1'b0, ADDR_DATA, 32'h0);
		chk(rd, 32'h0000_005A);
		wait_peer(5);
		// Lock requested mid-reception takes hold after the character
		bus(1'b1, ADDR_GATE, 32'h0);
		bus(1'b1, ADDR_HD, 32'h1);
		fork
			utg_peer_i.send(8'hC3);
			begin
				repeat (3 * BC) @(posedge clk);
				put(8'h11);
				stat(ST_RX_LOCKED, 1'b0);
			end
		join
		repeat (2 * BC) @(posedge clk);
		stat(ST_RX_LOCKED, 1'b1);
		bus(1'b0, ADDR_DATA, 32'h0);
		chk(rd, 32'h0000_00C3);
		bus(1'b1, ADDR_HD, 32'h0);
		bus(1'b1, ADDR_GATE, 32'h0000_0080);
		wait_peer(6);
		// Everything sent arrived whole and in order
		chk(32'(utg_peer_i.got.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) chk({24'h0, utg_peer_i.got[i]}, {24'h0, exp_q[i]});
		// Frame with a low stop bit sets the sticky error, a status read clears it
		utg_peer_i.send_raw({1'b0, 8'h81, 1'b0});
		repeat (2 * BC) @(posedge clk);
		stat(ST_FRAME_ERR, 1'b1);
		stat(ST_FRAME_ERR, 1'b0);
		// Reset in mid-run restores the permit and full duplex
		bus(1'b1, ADDR_GATE, 32'h0);
		bus(1'b1, ADDR_HD, 32'h1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, ADDR_GATE, 32'h0);
		chk(rd, 32'h0000_0080);
		bus(1'b0, ADDR_HD, 32'h0);
		chk(rd, 32'h0);
		test_done();
	end
endmodule
